// ---- common/psd_pkg.sv ----
package psd_pkg;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int DB_W = 7;

   // Register offsets
   localparam logic [ADDR_W-1:0] OFF_ASD = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_RDB = 4'h1;
   localparam logic [ADDR_W-1:0] OFF_MCR = 4'h2;
   localparam logic [ADDR_W-1:0] OFF_LIMIT = 4'h3;
   localparam logic [ADDR_W-1:0] OFF_DUTY = 4'h4;
   localparam logic [ADDR_W-1:0] OFF_TCR = 4'h5;
   localparam logic [ADDR_W-1:0] OFF_DRV = 4'h6;
   localparam logic [ADDR_W-1:0] OFF_TIMER = 4'h7;

   // Reset values
   localparam logic [DATA_W-1:0] RST_ASD = 8'h00;
   localparam logic [DATA_W-1:0] RST_RDB = 8'h00;
   localparam logic [DATA_W-1:0] RST_MCR = 8'h00;
   localparam logic [DATA_W-1:0] RST_LIMIT = 8'hff;
   localparam logic [DATA_W-1:0] RST_DUTY = 8'h00;
   localparam logic [DATA_W-1:0] RST_TCR = 8'h00;
   localparam logic [DATA_W-1:0] RST_DRV = 8'h00;

   // auto_shutdown_control fields
   localparam int ASD_STATUS_BIT = 7;
   localparam int ASD_SRC_LSB = 4;
   localparam int ASD_A_LSB = 2;
   localparam int ASD_B_LSB = 0;
   localparam int SRC_CMP_BIT = 0;
   localparam int SRC_INT_BIT = 2;
   // Shutdown state field: bit 1 set means tri-state, else bit 0 is the level
   localparam int SDS_TRI_BIT = 1;

   // restart_and_deadband_control fields
   localparam int RDB_RESTART_BIT = 7;

   // module_control_register fields
   localparam int MCR_HALF_BIT = 7;
   localparam int MCR_ENABLE_BIT = 2;
   localparam int MCR_POL_LSB = 0;

   // Timer control and driver enable fields
   localparam int TCR_RUN_BIT = 0;
   localparam int TCR_FLAG_BIT = 1;
   localparam int TCR_SYNC_BIT = 2;
   localparam int DRV_LSB = 0;

   // One instruction cycle is four oscillator periods
   localparam int INSTR_DIV = 4;
   localparam int INSTR_W = 2;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } psd_bus_req_t;

   typedef struct packed {
      logic level;
      logic oeN;
   } psd_pin_t;

   typedef enum logic [1:0] {SD_RUN, SD_HALT, SD_RESUME} psd_sd_state_t;

endpackage

// ---- rtl/psd_stage.sv ----
`timescale 1ns/1ns
// What this block does
// [RQ1] A two-bit polarity field picks active-high or active-low per output.
// [RQ2] Software picks polarity before enabling the pin drivers.
// [RQ3] Software runs one full period before enabling the pin drivers.
// [RQ4] The period flag is set as each new period, including the second, begins.
// [RQ5] After reset both pins float until software enables their drivers.
// [RQ6] Sleep freezes timer and all state except the pin synchronisers and read data; pins keep their value.
// [RQ7] Source field: bit 0 selects comparator, bit 2 selects low interrupt pin.
// [RQ8] Firmware writing the status bit to one causes a shutdown.
// [RQ9] Any shutdown event sets the status bit.
// [RQ10] Status bit reads one while shutdown is in force; outputs stay held after it clears until the next period start.
// [RQ11] Shutdown forces enabled pins without waiting for the period.
// [RQ12] Output A shutdown: 00 low, 01 high, 1x tri-state.
// [RQ13] Output B shutdown: 00 low, 01 high, 1x tri-state.
// [RQ14] Status stays set until firmware or auto-restart clears it.
// [RQ15] Shutdown is level based and persists while the source level stays.
// [RQ16] Status bit writes are ignored while a shutdown condition is present.
// [RQ17] After restart the outputs resume only at the next period start.
// [RQ18] With auto-restart set, hardware clears status when the condition ends.
// [RQ19] Without auto-restart, software clears status to restart.
// [RQ20] With comparator sync on, comparator shutdown waits for secondary timer tick.
// [RQ21] Dead band delays only the inactive-to-active edge in half-bridge mode.
// [RQ22] Seven-bit dead band counts instruction cycles of four clocks each.
// [RQ23] Half-bridge: output A carries the PWM, output B its complement.
// [RQ24] Dead band longer than the active time keeps that output inactive.
module psd_stage
   import psd_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Register port
   input wire psd_bus_req_t busReq,
   output logic [DATA_W-1:0] rdData,
   // Device state and shutdown sources
   input wire logic sleepReq,
   input wire logic intPin,
   input wire logic cmpOut,
   input wire logic secondaryTick,
   // Output pins
   output psd_pin_t pwmOutA,
   output psd_pin_t pwmOutB
);

   // Registers
   logic [DATA_W-1:0] asdCtrl_q;
   logic [DATA_W-1:0] rdbCtrl_q;
   logic [DATA_W-1:0] modCtrl_q;
   logic [DATA_W-1:0] periodLimit_q;
   logic [DATA_W-1:0] duty_q;
   logic [DATA_W-1:0] timerCtrl_q;
   logic [DATA_W-1:0] drvEn_q;
   logic statusBit_q;
   logic statusBit_d;
   logic periodFlag_q;

   // Timer
   logic [INSTR_W-1:0] divCnt_q;
   logic instrEn;
   logic [DATA_W-1:0] periodTimer_q;
   logic periodStart;
   logic armed_q;
   logic rawPwm;

   // Shutdown
   logic intMeta_q;
   logic intSync_q;
   logic cmpMeta_q;
   logic cmpSync_q;
   logic cmpHeld_q;
   logic cmpEff;
   logic condition;
   logic wrAsd;
   logic fwSet;
   logic fwClr;
   logic autoClr;
   psd_sd_state_t sdState_q;

   // Output path
   logic halfMode;
   logic [1:0] target;
   logic [1:0] active;
   logic [1:0] pinLevel_q;
   logic [1:0] pinOeN_q;
   logic [1:0] polLow;
   logic [3:0] sdField;

   logic run;
   assign run = !sleepReq; // [RQ6]
   assign halfMode = modCtrl_q[MCR_HALF_BIT];
   assign polLow = modCtrl_q[MCR_POL_LSB +: 2];
   assign sdField = {asdCtrl_q[ASD_A_LSB +: 2], asdCtrl_q[ASD_B_LSB +: 2]};
   assign wrAsd = busReq.wr && (busReq.addr == OFF_ASD);

   // Pin synchronisers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         intMeta_q <= 1'b1;
         intSync_q <= 1'b1;
         cmpMeta_q <= 1'b0;
         cmpSync_q <= 1'b0;
      end else begin
         intMeta_q <= intPin;
         intSync_q <= intMeta_q;
         cmpMeta_q <= cmpOut;
         cmpSync_q <= cmpMeta_q;
      end
   end

   // Instruction cycle enable
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         divCnt_q <= '0;
      end else if (run) begin // [RQ6]
         divCnt_q <= divCnt_q + 1'b1;
      end
   end
   assign instrEn = run && (divCnt_q == INSTR_W'(INSTR_DIV - 1)); // [RQ22]

   // Period timer
   assign periodStart = instrEn && timerCtrl_q[TCR_RUN_BIT] && (periodTimer_q == periodLimit_q);
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         periodTimer_q <= '0;
      end else if (instrEn && timerCtrl_q[TCR_RUN_BIT]) begin // [RQ6]
         periodTimer_q <= periodStart ? '0 : periodTimer_q + 1'b1;
      end
   end
   assign rawPwm = periodTimer_q < duty_q;

   // Waveform starts only at a period boundary, never mid-period
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         armed_q <= 1'b0;
      end else if (run) begin
         if (!modCtrl_q[MCR_ENABLE_BIT]) begin
            armed_q <= 1'b0;
         end else if (periodStart) begin
            armed_q <= 1'b1;
         end
      end
   end

   // Period flag: hardware set wins over a software clear
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         periodFlag_q <= 1'b0;
      end else if (run) begin
         if (periodStart) begin
            periodFlag_q <= 1'b1; // [RQ4]
         end else if (busReq.wr && busReq.addr == OFF_TCR && !busReq.wdata[TCR_FLAG_BIT]) begin
            periodFlag_q <= 1'b0;
         end
      end
   end

   // Comparator source optionally retimed to the secondary timer
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cmpHeld_q <= 1'b0;
      end else if (run && secondaryTick) begin // [RQ20]
         cmpHeld_q <= cmpSync_q;
      end
   end
   assign cmpEff = timerCtrl_q[TCR_SYNC_BIT] ? cmpHeld_q : cmpSync_q; // [RQ20]

   // Level-based condition from the selected sources
   assign condition = (asdCtrl_q[ASD_SRC_LSB + SRC_CMP_BIT] && cmpEff) || // [RQ7] [RQ15]
                      (asdCtrl_q[ASD_SRC_LSB + SRC_INT_BIT] && !intSync_q); // [RQ7] [RQ15]

   assign fwSet = wrAsd && busReq.wdata[ASD_STATUS_BIT] && !condition; // [RQ8] [RQ16]
   assign fwClr = wrAsd && !busReq.wdata[ASD_STATUS_BIT] && !condition; // [RQ16] [RQ19]
   assign autoClr = rdbCtrl_q[RDB_RESTART_BIT] && !condition; // [RQ18]

   always_comb begin
      statusBit_d = statusBit_q;
      if (condition || fwSet) begin
         statusBit_d = 1'b1; // [RQ9] [RQ15]
      end else if (fwClr || autoClr) begin
         statusBit_d = 1'b0; // [RQ14] [RQ18] [RQ19]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         statusBit_q <= RST_ASD[ASD_STATUS_BIT];
      end else if (run) begin // [RQ6]
         statusBit_q <= statusBit_d;
      end
   end

   // Shutdown sequencing: halt follows status, resume waits for a new period
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sdState_q <= SD_RUN;
      end else if (run) begin
         case (sdState_q)
            SD_RUN: begin
               if (statusBit_d) begin
                  sdState_q <= SD_HALT; // [RQ11]
               end
            end
            SD_HALT: begin
               if (!statusBit_d) begin
                  sdState_q <= SD_RESUME;
               end
            end
            SD_RESUME: begin
               if (statusBit_d) begin
                  sdState_q <= SD_HALT;
               end else if (periodStart) begin
                  sdState_q <= SD_RUN; // [RQ17]
               end
            end
            default: begin
               sdState_q <= SD_HALT;
            end
         endcase
      end
   end

   // Scheduled active levels before dead band
   assign target[0] = armed_q && rawPwm; // [RQ23]
   assign target[1] = armed_q && halfMode && !rawPwm; // [RQ23]

   // Per output dead band, polarity and shutdown override
   for (genvar ch = 0; ch < 2; ch++) begin : gChan
      logic [DB_W-1:0] dbCnt_q;
      logic act_q;
      logic [1:0] sdSel;
      assign sdSel = sdField[2*(1-ch) +: 2];
      assign active[ch] = act_q;

      // Falling edge is immediate; rising edge waits out the count
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            dbCnt_q <= '0;
            act_q <= 1'b0;
         end else if (run) begin
            if (!target[ch]) begin
               act_q <= 1'b0; // [RQ21]
               dbCnt_q <= halfMode ? rdbCtrl_q[DB_W-1:0] : '0; // [RQ22]
            end else if (dbCnt_q == '0) begin
               act_q <= 1'b1; // [RQ21] [RQ24]
            end else if (instrEn) begin
               dbCnt_q <= dbCnt_q - 1'b1; // [RQ22]
            end
         end
      end

      // Drivers off leaves the pin floating whatever the module does
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            pinLevel_q[ch] <= 1'b0;
            pinOeN_q[ch] <= 1'b1; // [RQ5]
         end else if (run) begin // [RQ6]
            if (statusBit_d || sdState_q != SD_RUN) begin
               pinLevel_q[ch] <= sdSel[0]; // [RQ11] [RQ12] [RQ13]
               pinOeN_q[ch] <= !drvEn_q[DRV_LSB + ch] || sdSel[SDS_TRI_BIT]; // [RQ12] [RQ13]
            end else begin
               pinLevel_q[ch] <= active[ch] ^ polLow[ch]; // [RQ1]
               pinOeN_q[ch] <= !drvEn_q[DRV_LSB + ch]; // [RQ5]
            end
         end
      end
   end

   assign pwmOutA = '{level: pinLevel_q[0], oeN: pinOeN_q[0]};
   assign pwmOutB = '{level: pinLevel_q[1], oeN: pinOeN_q[1]};

   // Register writes; the status bit is kept apart above
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         asdCtrl_q <= RST_ASD;
         rdbCtrl_q <= RST_RDB;
         modCtrl_q <= RST_MCR;
         periodLimit_q <= RST_LIMIT;
         duty_q <= RST_DUTY;
         timerCtrl_q <= RST_TCR;
         drvEn_q <= RST_DRV;
      end else if (busReq.wr && run) begin
         case (busReq.addr)
            OFF_ASD: asdCtrl_q <= busReq.wdata & ~(8'h01 << ASD_STATUS_BIT);
            OFF_RDB: rdbCtrl_q <= busReq.wdata;
            OFF_MCR: modCtrl_q <= busReq.wdata; // [RQ1]
            OFF_LIMIT: periodLimit_q <= busReq.wdata;
            OFF_DUTY: duty_q <= busReq.wdata;
            OFF_TCR: timerCtrl_q <= busReq.wdata & ~(8'h01 << TCR_FLAG_BIT);
            OFF_DRV: drvEn_q <= busReq.wdata & 8'h03;
            default: begin
            end
         endcase
      end
   end

   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdData <= '0;
      end else if (busReq.rd) begin
         case (busReq.addr)
            OFF_ASD: rdData <= asdCtrl_q | (DATA_W'(statusBit_q) << ASD_STATUS_BIT); // [RQ10]
            OFF_RDB: rdData <= rdbCtrl_q;
            OFF_MCR: rdData <= modCtrl_q;
            OFF_LIMIT: rdData <= periodLimit_q;
            OFF_DUTY: rdData <= duty_q;
            OFF_TCR: rdData <= timerCtrl_q | (DATA_W'(periodFlag_q) << TCR_FLAG_BIT);
            OFF_DRV: rdData <= drvEn_q;
            OFF_TIMER: rdData <= periodTimer_q;
            default: rdData <= '0;
         endcase
      end else begin
         rdData <= '0;
      end
   end

endmodule

// ---- verif/psd_stage_checker.sv ----
`timescale 1ns/1ns
module psd_stage_checker
   import psd_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Register port
   input wire psd_bus_req_t busReq,
   input wire logic [DATA_W-1:0] rdData,
   // Sources and pins
   input wire logic sleepReq,
   input wire logic intPin,
   input wire logic cmpOut,
   input wire logic secondaryTick,
   input wire psd_pin_t pwmOutA,
   input wire psd_pin_t pwmOutB
);
   logic [6:0] asdQ;
   logic [1:0] drvQ;
   logic syncQ;
   logic wrOk;
   assign wrOk = busReq.wr && !sleepReq;
   // Shadow of the written fields; status bit left out as hardware owns it
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         asdQ <= '0;
         drvQ <= '0;
         syncQ <= 1'b0;
      end else if (wrOk) begin
         if (busReq.addr == OFF_ASD) asdQ <= busReq.wdata[6:0];
         if (busReq.addr == OFF_DRV) drvQ <= busReq.wdata[1:0];
         if (busReq.addr == OFF_TCR) syncQ <= busReq.wdata[TCR_SYNC_BIT];
      end
   end
   function automatic logic inSd(psd_pin_t p, logic [1:0] s);
      return s[1] ? p.oeN : (!p.oeN && p.level == s[0]);
   endfunction
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   AST_RESET_FLOAT: assert property ($past(rst) |-> pwmOutA.oeN && pwmOutB.oeN)
      else $error("Pins driven right after reset");
   AST_SLEEP_HOLD: assert property (sleepReq |=> $stable(pwmOutA) && $stable(pwmOutB))
      else $error("Pins moved during sleep");
   AST_INT_A: assert property ((!intPin && asdQ[6] && drvQ[0] && !busReq.wr && !sleepReq)[*4]
      |-> inSd(pwmOutA, asdQ[3:2]))
      else $error("Output A not in shutdown state on low interrupt pin");
   AST_CMP_B: assert property ((cmpOut && asdQ[4] && !syncQ && drvQ[1] && !busReq.wr
      && !sleepReq)[*4] |-> inSd(pwmOutB, asdQ[1:0]))
      else $error("Output B not in shutdown state on comparator");
   AST_FW_A: assert property (wrOk && busReq.addr == OFF_ASD && busReq.wdata[7] && drvQ[0]
      |=> ##1 inSd(pwmOutA, asdQ[3:2]))
      else $error("Firmware shutdown did not force output A");
   AST_FW_B: assert property ($past(wrOk && busReq.addr == OFF_ASD && busReq.wdata[7], 2)
      && drvQ[1] |-> inSd(pwmOutB, asdQ[1:0]))
      else $error("Firmware shutdown did not force output B");
   AST_DRV_A: assert property ((!drvQ[0] && !sleepReq)[*2] |-> pwmOutA.oeN)
      else $error("Output A driven with driver off");
   AST_DRV_B: assert property ((!drvQ[1] && !sleepReq)[*2] |-> pwmOutB.oeN)
      else $error("Output B driven with driver off");
   COV_INT: cover property ((!intPin && asdQ[6] && drvQ[0])[*8]);
   COV_CMP: cover property ((cmpOut && asdQ[4] && drvQ[1])[*8]);
   COV_SLEEP: cover property (sleepReq[*8]);
endmodule

bind psd_stage psd_stage_checker chk (.sys_clk(sys_clk), .rst(rst), .busReq(busReq),
   .rdData(rdData), .sleepReq(sleepReq), .intPin(intPin), .cmpOut(cmpOut),
   .secondaryTick(secondaryTick), .pwmOutA(pwmOutA), .pwmOutB(pwmOutB));

// ---- verif/psd_switch_model.sv ----
`timescale 1ns/1ns
module psd_switch_model
   import psd_pkg::*;
(
   // Gate drive pins
   input wire psd_pin_t pwmOutA,
   input wire psd_pin_t pwmOutB,
   // Switch gates behind the pull-downs
   output logic gateHi,
   output logic gateLo,
   output logic shootThru
);
   // Pull-downs keep both switches off while a pin floats
   assign gateHi = pwmOutA.oeN ? 1'b0 : pwmOutA.level;
   assign gateLo = pwmOutB.oeN ? 1'b0 : pwmOutB.level;
   assign shootThru = gateHi && gateLo;
endmodule

// ---- verif/psd_stage_bench.sv ----
`timescale 1ns/1ns
module psd_stage_bench;
   import psd_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   psd_bus_req_t busReq = '0;
   logic sleepReq = 1'b0;
   logic intPin = 1'b1;
   logic cmpOut = 1'b0;
   logic secondaryTick = 1'b0;
   logic [DATA_W-1:0] rdData;
   psd_pin_t pwmOutA;
   psd_pin_t pwmOutB;
   logic gateHi;
   logic gateLo;
   logic shootThru;
   logic [7:0] v;
   int num_errors = 0;
   int checks_done = 0;
   int nA;
   int nB;
   int nS;
   int a0;
   int b0;

   always #4 sys_clk = ~sys_clk;

   psd_stage dut (.sys_clk(sys_clk), .rst(rst), .busReq(busReq), .rdData(rdData),
      .sleepReq(sleepReq), .intPin(intPin), .cmpOut(cmpOut), .secondaryTick(secondaryTick),
      .pwmOutA(pwmOutA), .pwmOutB(pwmOutB));
   psd_switch_model sw (.pwmOutA(pwmOutA), .pwmOutB(pwmOutB), .gateHi(gateHi),
      .gateLo(gateLo), .shootThru(shootThru));

   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task close_out;
      $display("Mismatches %0d, comparisons %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task waitN(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task doWrite(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      busReq.wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task rdGet(input logic [3:0] a);
      @(posedge sys_clk);
      busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      busReq.rd <= 1'b0;
      #1 v = rdData;
   endtask
   task rdChk(input logic [3:0] a, input logic [7:0] exp);
      rdGet(a);
      chk(v, exp);
   endtask
   function automatic logic [7:0] pinView();
      return {4'h0, gateHi, pwmOutA.oeN, gateLo, pwmOutB.oeN};
   endfunction
   // Window of exactly two periods, so the count does not depend on phase
   task measure;
      nA = 0;
      nB = 0;
      nS = 0;
      waitN(32);
      repeat (64) begin
         @(negedge sys_clk);
         nA += int'(gateHi);
         nB += int'(gateLo);
         nS += int'(shootThru);
      end
   endtask
   task waitFlag;
      for (int i = 0; i < 40; i++) begin
         rdGet(OFF_TCR);
         if (v[TCR_FLAG_BIT] === 1'b1) begin
            chk(v, 8'h03);
            return;
         end
      end
      num_errors++;
      close_out();
   endtask

   task resetVals;
      @(negedge sys_clk);
      chk(pinView(), 8'h05);
      rdChk(OFF_ASD, RST_ASD);
      rdChk(OFF_RDB, RST_RDB);
      rdChk(OFF_LIMIT, RST_LIMIT);
      rdChk(4'h9, 8'h00);
   endtask
   task setup;
      doWrite(OFF_LIMIT, 8'h07);
      doWrite(OFF_DUTY, 8'h04);
      doWrite(OFF_MCR, 8'h84);
      doWrite(OFF_TCR, 8'h01);
      waitFlag();
      doWrite(OFF_TCR, 8'h01);
      waitFlag();
      doWrite(OFF_DRV, 8'h03);
   endtask
   task deadBand;
      measure();
      a0 = nA;
      b0 = nB;
      chk(8'(a0), 8'd32);
      chk(8'(b0), 8'd32);
      doWrite(OFF_RDB, 8'h02);
      measure();
      chk(8'(a0 - nA), 8'd16);
      chk(8'(b0 - nB), 8'd16);
      chk(8'(nS), 8'h00);
      doWrite(OFF_RDB, 8'h05);
      measure();
      chk(8'(nA + nB), 8'h00);
      doWrite(OFF_RDB, 8'h00);
      doWrite(OFF_DRV, 8'h00);
      doWrite(OFF_MCR, 8'h87);
      doWrite(OFF_DRV, 8'h03);
      measure();
      chk(8'(64 - nA), 8'd32);
      chk(8'(64 - nB), 8'd32);
      doWrite(OFF_DRV, 8'h00);
      doWrite(OFF_MCR, 8'h04);
      doWrite(OFF_DRV, 8'h03);
      measure();
      chk(8'(nA), 8'd32);
      chk(8'(nB), 8'h00);
      doWrite(OFF_DRV, 8'h00);
      doWrite(OFF_MCR, 8'h84);
      doWrite(OFF_DRV, 8'h03);
   endtask
   task intShutdown;
      doWrite(OFF_ASD, 8'h21);
      intPin <= 1'b0;
      waitN(6);
      rdChk(OFF_ASD, 8'h21);
      doWrite(OFF_ASD, 8'h41);
      waitN(6);
      rdChk(OFF_ASD, 8'hc1);
      @(negedge sys_clk);
      chk(pinView(), 8'h02);
      doWrite(OFF_ASD, 8'h41);
      waitN(20);
      rdChk(OFF_ASD, 8'hc1);
      @(posedge sys_clk);
      intPin <= 1'b1;
      waitN(6);
      rdChk(OFF_ASD, 8'hc1);
      doWrite(OFF_ASD, 8'h41);
      @(negedge sys_clk);
      chk(pinView(), 8'h02);
      rdChk(OFF_ASD, 8'h41);
      measure();
      chk(8'(nA), 8'd32);
   endtask
   task fwCodes;
      for (int s = 0; s < 4; s++) begin
         doWrite(OFF_ASD, 8'h80 | 8'(s * 5));
         // Write edge still forces with the old fields
         @(posedge sys_clk);
         @(negedge sys_clk);
         chk(pinView(), {4'h0, s == 1, s > 1, s == 1, s > 1});
         rdChk(OFF_ASD, 8'h80 | 8'(s * 5));
         doWrite(OFF_ASD, 8'(s * 5));
         rdChk(OFF_ASD, 8'(s * 5));
      end
   endtask
   task cmpRun(input logic [7:0] asdMid);
      cmpOut <= 1'b1;
      waitN(8);
      rdChk(OFF_ASD, asdMid);
      @(posedge sys_clk);
      secondaryTick <= 1'b1;
      @(posedge sys_clk);
      secondaryTick <= 1'b0;
      waitN(4);
      rdChk(OFF_ASD, 8'h90);
      @(posedge sys_clk);
      cmpOut <= 1'b0;
      // Tick only after the synchroniser shows the low level, else a stale high is held
      waitN(3);
      secondaryTick <= 1'b1;
      @(posedge sys_clk);
      secondaryTick <= 1'b0;
      waitN(6);
      rdChk(OFF_ASD, 8'h10);
   endtask
   task autoRestart;
      doWrite(OFF_RDB, 8'h80);
      doWrite(OFF_ASD, 8'h10);
      cmpRun(8'h90);
      doWrite(OFF_TCR, 8'h05);
      cmpRun(8'h10);
      doWrite(OFF_TCR, 8'h01);
      doWrite(OFF_RDB, 8'h00);
   endtask
   task sleepHold;
      @(posedge sys_clk);
      sleepReq <= 1'b1;
      @(negedge sys_clk);
      v = pinView();
      doWrite(OFF_DUTY, 8'h00);
      waitN(40);
      @(negedge sys_clk);
      chk(pinView(), v);
      @(posedge sys_clk);
      sleepReq <= 1'b0;
      rdChk(OFF_DUTY, 8'h04);
   endtask

   initial begin
      waitN(5);
      rst <= 1'b0;
      resetVals();
      setup();
      deadBand();
      intShutdown();
      fwCodes();
      autoRestart();
      sleepHold();
      close_out();
   end
endmodule
